// ### core/rsv_event_sync.sv
`timescale 1ns/1ps
module rsv_event_sync
    import rsv_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic event_pin,
    output logic event_pulse
);
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic pulse_reg;
    logic pulse_next;

    // Two stages before use; third stage only feeds the edge detector
    always_comb
    begin
        sync_next = {sync_reg[1:0], event_pin};
        pulse_next = sync_reg[1] & ~sync_reg[2];
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_reg <= 3'h0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= sync_next;
            pulse_reg <= pulse_next;
        end
    end

    assign event_pulse = pulse_reg;

    AST_PULSE_ONE: assert property (@(posedge clock) disable iff (!arst_n)
        event_pulse |=> !event_pulse)
        else $error("event pulse longer than one cycle");

endmodule : rsv_event_sync

// ### core/rsv_pkg.sv
package rsv_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_IN_NS = 1000000;
    localparam int unsigned CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_UNIT_MS = 2;
    localparam int unsigned DELAY_STEP_MS = 256;

    // Bus geometry and answers
    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_MAX_COUNT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;

    // Reset values
    localparam logic [7:0] CTRL_A_RST = 8'h88;
    localparam logic [7:0] CTRL_B_RST = 8'h19;
    localparam logic [3:0] MAX_COUNT_RST = 4'h6;

    // Field positions and widths
    localparam int unsigned ENABLE_BIT = 7;
    localparam int unsigned DELAY_LSB = 4;
    localparam int unsigned CONFIRM_LSB = 1;
    localparam int unsigned ASSERT_W = 6;
    localparam int unsigned MAX_COUNT_W = 4;
    localparam int unsigned MS_W = 11;
    localparam int unsigned ST_VALID_BIT = 0;
    localparam int unsigned ST_TOO_LOW_BIT = 1;
    localparam int unsigned ST_TOO_HIGH_BIT = 2;
    localparam int unsigned ST_STATE_LSB = 4;
    localparam int unsigned ST_TIMER_LSB = 8;

    // Confirmation times in ms, indexed by code
    localparam logic [10:0] CONFIRM_MS [8] = '{
        11'h064, 11'h096, 11'h0c8, 11'h100,
        11'h180, 11'h200, 11'h280, 11'h400
    };

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_QUAL = 2'b01,
        ST_DELAY = 2'b10,
        ST_VALID = 2'b11
    } rsv_state_t;

    function automatic logic [10:0] rsv_confirm_ms(input logic [2:0] code);
        rsv_confirm_ms = CONFIRM_MS[code];
    endfunction : rsv_confirm_ms

    function automatic logic [10:0] rsv_delay_ms(input logic [2:0] code);
        rsv_delay_ms = 11'({code, 8'h00}) * 11'(DELAY_STEP_MS / 256);
    endfunction : rsv_delay_ms

endpackage : rsv_pkg

// ### core/rsv_ring_validator.sv
`timescale 1ns/1ps
// Operation
// - Qualification runs only while the enable bit (bit 7, control A) is set.
// - After validation wait 256 ms per delay code step before reporting.
// - Valid only after frequency stays in range for the coded confirm time.
// - Each threshold event reloads the timer, which counts down regularly.
// - Later event after timer expiry means frequency too low; invalidate.
// - Assertion and max count fields count in 2 ms units.
// - Later event with remaining timer above max count means too high.
module rsv_ring_validator
    import rsv_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ring_event_pin,
    output logic ring_valid,
    input wire logic [rsv_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rsv_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rsv_pkg::*;

    logic event_pulse;
    logic tick_1ms;
    logic tick_2ms;

    rsv_event_sync u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .event_pin(ring_event_pin),
        .event_pulse(event_pulse)
    );

    rsv_tick_gen #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tick (
        .clock(clock),
        .arst_n(arst_n),
        .tick_1ms(tick_1ms),
        .tick_2ms(tick_2ms)
    );

    // Map a byte address to a register slot; 4 means unmapped
    function automatic logic [2:0] reg_slot(input logic [7:0] addr);
        unique case (addr)
            OFF_CTRL_A: reg_slot = 3'h0;
            OFF_CTRL_B: reg_slot = 3'h1;
            OFF_MAX_COUNT: reg_slot = 3'h2;
            OFF_STATUS: reg_slot = 3'h3;
            default: reg_slot = 3'h4;
        endcase
    endfunction : reg_slot

    // Bus channel state
    logic aw_full_reg, aw_full_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic w_full_reg, w_full_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic wr_fire;
    logic [2:0] wr_slot;

    // Registers and qualification state
    logic [7:0] ctrl_a_reg, ctrl_a_next;
    logic [5:0] ctrl_b_reg, ctrl_b_next;
    logic [3:0] max_cnt_reg, max_cnt_next;
    logic too_low_reg, too_low_next;
    logic too_high_reg, too_high_next;
    rsv_state_t state_reg, state_next;
    logic [5:0] timer_reg, timer_next;
    logic [10:0] ms_cnt_reg, ms_cnt_next;
    logic valid_reg, valid_next;

    logic enable;
    logic [2:0] delay_code;
    logic [10:0] confirm_ms;
    logic [10:0] delay_ms;
    logic [10:0] ms_plus;
    logic late_low;
    logic late_high;
    logic restart;
    logic [31:0] status_word;

    assign enable = ctrl_a_reg[ENABLE_BIT];
    assign delay_code = ctrl_a_reg[DELAY_LSB +: 3];
    assign confirm_ms = rsv_confirm_ms(ctrl_a_reg[CONFIRM_LSB +: 3]);
    assign delay_ms = rsv_delay_ms(delay_code);
    assign ms_plus = ms_cnt_reg + 11'h001;
    assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_slot = reg_slot(aw_addr_reg);
    // Late event judged against the timer before its reload
    assign late_low = event_pulse & (state_reg != ST_IDLE)
        & (timer_reg == 6'h00);
    assign late_high = event_pulse & (state_reg != ST_IDLE)
        & (timer_reg > {2'h0, max_cnt_reg});
    // Only a first or out-of-range event restarts the window
    assign restart = event_pulse & ((state_reg == ST_IDLE) | late_low
        | late_high);
    assign status_word = {16'h0000, 2'h0, timer_reg, 2'h0, state_reg,
        1'b0, too_high_reg, too_low_reg, valid_reg};

    // AXI4-Lite slave; address and data may arrive in either order
    always_comb
    begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wr_slot == 3'h4) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            unique case (reg_slot(s_axi_araddr))
                3'h0: rdata_next = {24'h000000, ctrl_a_reg};
                3'h1: rdata_next = {26'h0000000, ctrl_b_reg};
                3'h2: rdata_next = {28'h0000000, max_cnt_reg};
                3'h3: rdata_next = status_word;
                default:
                begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        // Ready stays low while a channel holds an untaken item
        awready_next = ~aw_full_next & ~bvalid_next;
        wready_next = ~w_full_next & ~bvalid_next;
        arready_next = ~rvalid_next;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Config writes, sticky flags and the qualification machine
    always_comb
    begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        max_cnt_next = max_cnt_reg;
        too_low_next = too_low_reg;
        too_high_next = too_high_reg;
        state_next = state_reg;
        timer_next = timer_reg;
        ms_cnt_next = ms_cnt_reg;
        valid_next = valid_reg;
        if (wr_fire && w_strb_reg[0])
        begin
            unique case (wr_slot)
                // Reserved low bit never stored
                3'h0: ctrl_a_next = {w_data_reg[7:1], 1'b0};
                3'h1: ctrl_b_next = w_data_reg[5:0];
                3'h2: max_cnt_next = w_data_reg[3:0];
                3'h3:
                begin
                    // Write one to clear; a new event below still wins
                    too_low_next = too_low_reg & ~w_data_reg[ST_TOO_LOW_BIT];
                    too_high_next = too_high_reg
                        & ~w_data_reg[ST_TOO_HIGH_BIT];
                end
                default:
                begin
                end
            endcase
        end
        if (!enable)
        begin
            state_next = ST_IDLE;
            timer_next = 6'h00;
            ms_cnt_next = 11'h000;
            valid_next = 1'b0;
        end
        else if (restart)
        begin
            // Out-of-range spacing restarts the confirmation window
            timer_next = ctrl_b_reg;
            state_next = ST_QUAL;
            ms_cnt_next = 11'h000;
            valid_next = 1'b0;
            too_low_next = too_low_next | late_low;
            too_high_next = too_high_next
                | (late_high & ~late_low);
        end
        else
        begin
            // In-range event reloads but must not swallow a ms tick
            if (event_pulse)
            begin
                timer_next = ctrl_b_reg;
            end
            else if (tick_2ms && timer_reg != 6'h00)
            begin
                timer_next = timer_reg - 6'h01;
            end
            unique case (state_reg)
                ST_IDLE:
                begin
                end
                ST_QUAL:
                begin
                    // Confirm only counts while spacing is still in range
                    if (tick_1ms && timer_reg != 6'h00)
                    begin
                        ms_cnt_next = ms_plus;
                        if (ms_plus >= confirm_ms)
                        begin
                            ms_cnt_next = 11'h000;
                            state_next = (delay_code == 3'h0) ? ST_VALID
                                : ST_DELAY;
                            valid_next = (delay_code == 3'h0);
                        end
                    end
                end
                ST_DELAY:
                begin
                    if (tick_1ms)
                    begin
                        ms_cnt_next = ms_plus;
                        if (ms_plus >= delay_ms)
                        begin
                            ms_cnt_next = 11'h000;
                            state_next = ST_VALID;
                            valid_next = 1'b1;
                        end
                    end
                end
                ST_VALID:
                begin
                    // Ring over once the timer runs out after reporting
                    if (timer_reg == 6'h00)
                    begin
                        state_next = ST_IDLE;
                        valid_next = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_a_reg <= CTRL_A_RST;
            ctrl_b_reg <= CTRL_B_RST[5:0];
            max_cnt_reg <= MAX_COUNT_RST;
            too_low_reg <= 1'b0;
            too_high_reg <= 1'b0;
            state_reg <= ST_IDLE;
            timer_reg <= 6'h00;
            ms_cnt_reg <= 11'h000;
            valid_reg <= 1'b0;
        end
        else
        begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            max_cnt_reg <= max_cnt_next;
            too_low_reg <= too_low_next;
            too_high_reg <= too_high_next;
            state_reg <= state_next;
            timer_reg <= timer_next;
            ms_cnt_reg <= ms_cnt_next;
            valid_reg <= valid_next;
        end
    end

    assign ring_valid = valid_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_DISABLED_IDLE: assert property (!enable |=>
        state_reg == ST_IDLE && !ring_valid)
        else $error("machine active while disabled");
    AST_RELOAD: assert property (enable && event_pulse
        |=> timer_reg == $past(ctrl_b_reg)) else $error("timer not reloaded");
    AST_COUNT_DOWN: assert property (enable && !event_pulse && tick_2ms
        && timer_reg != 6'h00 |=> timer_reg == $past(timer_reg) - 6'h01)
        else $error("timer did not step down");
    AST_TOO_LOW: assert property (enable && late_low
        |=> too_low_reg && !ring_valid && state_reg == ST_QUAL)
        else $error("slow ring not invalidated");
    AST_TOO_HIGH: assert property (enable && late_high && !late_low
        |=> too_high_reg && !ring_valid && ms_cnt_reg == 11'h000)
        else $error("fast ring not invalidated");
    AST_CONFIRM: assert property (state_reg == ST_QUAL ##1
        (state_reg == ST_DELAY || state_reg == ST_VALID)
        |-> $past(ms_plus) == $past(confirm_ms))
        else $error("confirm time wrong");
    AST_DELAY: assert property (state_reg == ST_DELAY ##1
        state_reg == ST_VALID |-> $past(ms_plus) == $past(delay_ms)
        && ring_valid) else $error("report delay wrong");
    AST_NO_DELAY: assert property ($rose(ring_valid)
        && $past(state_reg) == ST_QUAL |-> $past(delay_code) == 3'h0)
        else $error("report skipped its delay");
    AST_RSVD_BIT: assert property (ctrl_a_reg[0] == 1'b0)
        else $error("reserved bit stored");

    COV_VALID: cover property ($rose(ring_valid));
    COV_SLOW: cover property (enable && late_low);
    COV_FAST: cover property (enable && late_high && !late_low);
    COV_DELAYED: cover property (state_reg == ST_DELAY ##1
        state_reg == ST_VALID);

endmodule : rsv_ring_validator

// ### core/rsv_tick_gen.sv
`timescale 1ns/1ps
module rsv_tick_gen
    import rsv_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
)
(
    input wire logic clock,
    input wire logic arst_n,
    output logic tick_1ms,
    output logic tick_2ms
);
    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic half_reg;
    logic half_next;
    logic t1_reg;
    logic t1_next;
    logic t2_reg;
    logic t2_next;

    // Free-running prescaler; 2 ms tick is every other ms tick
    always_comb
    begin
        div_next = div_reg + 32'h1;
        t1_next = 1'b0;
        t2_next = 1'b0;
        half_next = half_reg;
        if (div_reg >= 32'(CYCLES_PER_MS - 1))
        begin
            div_next = 32'h0;
            t1_next = 1'b1;
            half_next = ~half_reg;
            t2_next = half_reg;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_reg <= 32'h0;
            half_reg <= 1'b0;
            t1_reg <= 1'b0;
            t2_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            half_reg <= half_next;
            t1_reg <= t1_next;
            t2_reg <= t2_next;
        end
    end

    assign tick_1ms = t1_reg;
    assign tick_2ms = t2_reg;

    AST_TICK2_ON_MS: assert property (@(posedge clock) disable iff (!arst_n)
        tick_2ms |-> tick_1ms)
        else $error("2 ms tick off the ms grid");

    AST_DIV_RANGE: assert property (@(posedge clock) disable iff (!arst_n)
        div_reg < 32'(CYCLES_PER_MS))
        else $error("prescaler out of range");

endmodule : rsv_tick_gen

// ### tb/ring_signal_validator_test.sv
`timescale 1ns/1ps
module ring_signal_validator_test;
    import rsv_pkg::*;
    localparam int CPM = 10;
    localparam int TOL = 30;
    logic clock, arst_n, run, pin, ring_valid;
    logic [15:0] gap;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, resp;
    int failures, checks, cycles, n, exp, dly;
    int conf_ms [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};

    rsv_ring_validator #(.CYCLES_PER_MS(CPM)) dut (
        .clock(clock), .arst_n(arst_n), .ring_event_pin(pin),
        .ring_valid(ring_valid),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    rsv_line_model line (
        .clock(clock), .arst_n(arst_n), .run(run), .gap(gap),
        .ring_event_pin(pin)
    );

    // Free-running clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // Write: address and data offered together, bready held to response
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axr

    // Hang guard; the full sweep needs roughly 69k cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            failures++;
            close_out();
        end
    end

    initial
    begin
        {arst_n, run, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        gap = 16'd400;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values, then unmapped places
        axr(OFF_CTRL_A, rd);
        check(rd, 32'h0000_0088);
        axr(OFF_CTRL_B, rd);
        check(rd, 32'h0000_0019);
        axr(OFF_MAX_COUNT, rd);
        check(rd, 32'h0000_0006);
        axr(8'h10, rd);
        check({rd[29:0], resp}, {30'h0, RESP_SLVERR});
        axw(8'h10, 32'h0000_0001);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        // Disabled: events must be ignored
        axw(OFF_CTRL_A, 32'h0000_0000);
        run <= 1'b1;
        repeat (1500) @(posedge clock);
        check({31'h0, ring_valid}, 32'h0);
        axr(OFF_STATUS, rd);
        check(rd & 32'h37, 32'h0);
        run <= 1'b0;
        // Spacing beyond assertion time: frequency too low
        axw(OFF_CTRL_A, 32'h0000_008e);
        gap <= 16'd600;
        run <= 1'b1;
        repeat (1500) @(posedge clock);
        axr(OFF_STATUS, rd);
        check(rd & 32'h6, 32'h2);
        run <= 1'b0;
        axw(OFF_STATUS, 32'h0000_0006);
        axr(OFF_STATUS, rd);
        check(rd & 32'h6, 32'h0);
        // Short spacing leaves timer above max count
        gap <= 16'd200;
        run <= 1'b1;
        repeat (8) @(posedge clock);
        axr(OFF_STATUS, rd);
        check({31'h0, rd[13:8] inside {6'd24, 6'd25}}, 32'h1);
        repeat (700) @(posedge clock);
        axr(OFF_STATUS, rd);
        check(rd & 32'h6, 32'h4);
        run <= 1'b0;
        axw(OFF_STATUS, 32'h0000_0006);
        // Every confirm code, delay codes 0, 1 and 7; 40 ms spacing
        gap <= 16'd400;
        for (int i = 0; i < 8; i++)
        begin
            dly = (i == 7) ? 7 : i % 2;
            axw(OFF_CTRL_A, 32'h0000_0000);
            axw(OFF_CTRL_A, {24'h0, 1'b1, dly[2:0], i[2:0], 1'b0});
            exp = (conf_ms[i] + 256 * dly) * CPM;
            run <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clock);
                n++;
            end while (!ring_valid && n < 30000);
            check({31'h0, n > exp - TOL && n < exp + TOL}, 32'h1);
            axr(OFF_STATUS, rd);
            check({30'h0, rd[5:4]}, 32'h3);
            run <= 1'b0;
            repeat (800) @(posedge clock);
            check({31'h0, ring_valid}, 32'h0);
        end
        // Reset in mid-ring must clear qualification and restore the control A reset value
        run <= 1'b1;
        repeat (300) @(posedge clock);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        run <= 1'b0;
        axr(OFF_STATUS, rd);
        check(rd, 32'h0);
        axr(OFF_CTRL_A, rd);
        check(rd, 32'h0000_0088);
        close_out();
    end
endmodule : ring_signal_validator_test

// ### tb/rsv_line_model.sv
`timescale 1ns/1ps
module rsv_line_model
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [15:0] gap,
    output logic ring_event_pin
);
    logic [15:0] cnt_reg;

    // One crossing per gap, held 4 clocks so the synchroniser sees it
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= 16'h0000;
            ring_event_pin <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg <= 16'h0000;
            ring_event_pin <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg + 16'h0001 >= gap) ? 16'h0000
                : cnt_reg + 16'h0001;
            ring_event_pin <= (cnt_reg < 16'h0004);
        end
    end
endmodule : rsv_line_model
